// ===== nvsq_pkg.sv
// Package with the constants of the nonvolatile command sequencer
package nvsq_pkg;
   // Clock
   localparam int CLK_PERIOD_PS = 8000;

   // Times as printed, and cycle counts rounded up as least waits
   localparam int ACCESS_NS          = 25;
   localparam int GAP_NS             = 10;
   localparam int POST_BUSY_DELAY_NS = 20;
   localparam int SAVE_START_NS      = 100;
   localparam int HW_PULSE_NS        = 50;
   localparam int RECALL_DURATION_NS = 200000;
   localparam int ACCESS_CYC     = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int GAP_CYC        = (GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int POST_BUSY_CYC  = (POST_BUSY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
   localparam int SAVE_START_CYC = (SAVE_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HW_PULSE_CYC   = (HW_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RECALL_CYC     = (RECALL_DURATION_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;

   // Widths
   localparam int TIMER_W = 24;
   localparam int ADDR_W  = 18;
   localparam int DATA_W  = 16;

   // Request operation codes on the command port
   localparam logic [2:0] OP_READ    = 3'h0;
   localparam logic [2:0] OP_WRITE   = 3'h1;
   localparam logic [2:0] OP_RECALL  = 3'h2;
   localparam logic [2:0] OP_SAVE    = 3'h3;
   localparam logic [2:0] OP_PF_OFF  = 3'h4;
   localparam logic [2:0] OP_PF_ON   = 3'h5;
   localparam logic [2:0] OP_HW_SAVE = 3'h6;

   // Sequence addresses
   localparam logic [15:0] SEQ_ADDR_0     = 16'h4E38;
   localparam logic [15:0] SEQ_ADDR_1     = 16'hB1C7;
   localparam logic [15:0] SEQ_ADDR_2     = 16'h83E0;
   localparam logic [15:0] SEQ_ADDR_3     = 16'h7C1F;
   localparam logic [15:0] SEQ_ADDR_4     = 16'h703F;
   localparam logic [15:0] SEQ_ADDR_RECALL = 16'h4C63;
   localparam logic [15:0] SEQ_ADDR_SAVE   = 16'h8FC0;
   localparam logic [15:0] SEQ_ADDR_PF_OFF = 16'h8B45;
   localparam logic [15:0] SEQ_ADDR_PF_ON  = 16'h4B46;
   localparam logic [2:0]  SEQ_LAST_STEP   = 3'h5;

   // Address of one sequence step for one command
   function automatic logic [15:0] nvsq_seq_addr(input logic [2:0] step, input logic [2:0] op);
      logic [15:0] a;
      a = SEQ_ADDR_0;
      case (step)
         3'h0: a = SEQ_ADDR_0;
         3'h1: a = SEQ_ADDR_1;
         3'h2: a = SEQ_ADDR_2;
         3'h3: a = SEQ_ADDR_3;
         3'h4: a = SEQ_ADDR_4;
         default: begin
            case (op)
               OP_RECALL: a = SEQ_ADDR_RECALL;
               OP_PF_OFF: a = SEQ_ADDR_PF_OFF;
               OP_PF_ON:  a = SEQ_ADDR_PF_ON;
               default:   a = SEQ_ADDR_SAVE;
            endcase
         end
      endcase
      return a;
   endfunction : nvsq_seq_addr

   // True for operations carried out by a six-read sequence
   function automatic logic nvsq_is_seq(input logic [2:0] op);
      return (op == OP_RECALL) || (op == OP_SAVE) || (op == OP_PF_OFF) || (op == OP_PF_ON);
   endfunction : nvsq_is_seq
endpackage : nvsq_pkg

// ===== nvsq_timer.sv
// Down-counting wait timer for the sequencer
`timescale 1ns/1ps
module nvsq_timer #(
   parameter int W = 24
) (
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] value_i,
   output logic              zero_o
);
   typedef struct packed {
      logic [W-1:0] count;
   } nvsq_tmr_s;

   nvsq_tmr_s st;
   nvsq_tmr_s next_st;

   // Load takes priority; otherwise count down to zero and stay
   always_comb begin
      next_st = st;
      if (load_i) begin
         next_st.count = value_i;
      end else if (st.count != '0) begin
         next_st.count = st.count - W'(1);
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign zero_o = (st.count == '0);
endmodule : nvsq_timer

// ===== nvsq_host.sv
// Host-side controller that drives the nonvolatile SRAM pins and issues command sequences
`timescale 1ns/1ps
module nvsq_host #(
   parameter int RECALL_WAIT_CYC = nvsq_pkg::RECALL_CYC,
   parameter bit SEQ_USE_OE      = 1'b0,
   parameter bit AUTO_SAVE_PF    = 1'b1
) (
   input  wire logic        CLK_I,
   input  wire logic        RST_B_I,
   input  wire logic        REQ_VALID_I,
   input  wire logic [2:0]  REQ_OP_I,
   input  wire logic [17:0] REQ_ADDR_I,
   input  wire logic [15:0] REQ_WDATA_I,
   input  wire logic [1:0]  REQ_BYTE_N_I,
   input  wire logic        LOW_SUPPLY_I,
   output logic             REQ_READY_O,
   output logic             RESP_VALID_O,
   output logic             RESP_ERR_O,
   output logic [15:0]      RESP_RDATA_O,
   output logic             BUSY_O,
   output logic [17:0]      MEM_ADDR_O,
   output logic             MEM_CE_N_O,
   output logic             MEM_OE_N_O,
   output logic             MEM_WE_N_O,
   output logic             MEM_UPPER_BYTE_SELECT_N_O,
   output logic             MEM_LOW_BYTE_SELECT_N_O,
   input  wire logic [15:0] MEM_DQ_I,
   output logic [15:0]      MEM_DQ_O,
   output logic             MEM_DQ_OE_N_O,
   input  wire logic        SAVE_BUSY_N_I,
   output logic             SAVE_BUSY_N_O,
   output logic             SAVE_BUSY_N_OE_N_O
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_ACCESS, ST_GAP, ST_HW_PULSE, ST_SAVE_START, ST_RECALL, ST_WAIT_BUSY,
      ST_HOLDOFF
   } nvsq_state_e;

   typedef struct packed {
      nvsq_state_e state;
      logic [2:0]  op;
      logic [2:0]  step;
      logic        more;
      logic        resp_due;
      logic [15:0] wdata;
      logic [17:0] req_addr;
      logic [17:0] addr;
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic [1:0]  byte_n;
      logic        dq_oe_n;
      logic        busy_oe_n;
      logic        ready;
      logic        resp_valid;
      logic        resp_err;
      logic [15:0] rdata;
      logic        busy;
   } nvsq_host_s;

   localparam logic [23:0] T_ACCESS  = 24'(nvsq_pkg::ACCESS_CYC);
   localparam logic [23:0] T_GAP     = 24'(nvsq_pkg::GAP_CYC);
   localparam logic [23:0] T_POST    = 24'(nvsq_pkg::POST_BUSY_CYC);
   localparam logic [23:0] T_SSTART  = 24'(nvsq_pkg::SAVE_START_CYC);
   localparam logic [23:0] T_HWPULSE = 24'(nvsq_pkg::HW_PULSE_CYC);
   localparam logic [23:0] T_RECALL  = 24'(RECALL_WAIT_CYC);

   nvsq_host_s  st;
   nvsq_host_s  next_st;
   logic        tmr_load;
   logic [23:0] tmr_value;
   logic        tmr_zero;

   // Wait timer shared by every timed phase
   nvsq_timer #(
      .W (nvsq_pkg::TIMER_W)
   ) u_timer (
      .clk_i   (CLK_I),
      .rst_b_i (RST_B_I),
      .load_i  (tmr_load),
      .value_i (tmr_value),
      .zero_o  (tmr_zero)
   );

   // Puts the pins into the first half of one access of the current op and step
   function automatic nvsq_host_s start_access(input nvsq_host_s s);
      nvsq_host_s n;
      n = s;
      n.state = ST_ACCESS;
      n.ce_n  = 1'b0;
      if (nvsq_pkg::nvsq_is_seq(s.op)) begin
         n.addr   = {2'h0, nvsq_pkg::nvsq_seq_addr(s.step, s.op)};
         n.we_n   = 1'b1;
         n.oe_n   = 1'b0;
         n.byte_n = 2'h0;
      end else begin
         n.addr    = s.req_addr;
         n.we_n    = (s.op != nvsq_pkg::OP_WRITE);
         n.oe_n    = (s.op == nvsq_pkg::OP_WRITE);
         n.dq_oe_n = (s.op != nvsq_pkg::OP_WRITE);
      end
      return n;
   endfunction : start_access

   // Next-state logic of the sequencer
   always_comb begin
      next_st            = st;
      next_st.resp_valid = 1'b0;
      tmr_load           = 1'b0;
      tmr_value          = T_ACCESS;
      case (st.state)
         ST_IDLE: begin
            next_st.ready = 1'b1;
            next_st.busy  = 1'b0;
            if (!SAVE_BUSY_N_I) begin
               next_st.ready = 1'b0;
               next_st.busy  = 1'b1;
               next_st.state = ST_WAIT_BUSY;
            end else if (REQ_VALID_I && st.ready) begin
               next_st.ready    = 1'b0;
               next_st.op       = REQ_OP_I;
               next_st.req_addr = REQ_ADDR_I;
               next_st.wdata    = REQ_WDATA_I;
               next_st.byte_n   = REQ_BYTE_N_I;
               next_st.step     = 3'h0;
               next_st.resp_err = 1'b0;
               if (LOW_SUPPLY_I && (REQ_OP_I == nvsq_pkg::OP_WRITE ||
                                    REQ_OP_I == nvsq_pkg::OP_SAVE ||
                                    REQ_OP_I == nvsq_pkg::OP_HW_SAVE)) begin
                  next_st.resp_valid = 1'b1;
                  next_st.resp_err   = 1'b1;
               end else if (REQ_OP_I == nvsq_pkg::OP_HW_SAVE) begin
                  next_st.busy      = 1'b1;
                  next_st.busy_oe_n = 1'b0;
                  next_st.state     = ST_HW_PULSE;
                  tmr_load          = 1'b1;
                  tmr_value         = T_HWPULSE;
               end else if (REQ_OP_I <= nvsq_pkg::OP_PF_ON) begin
                  next_st.busy = 1'b1;
                  next_st      = start_access(next_st);
                  tmr_load     = 1'b1;
               end else begin
                  next_st.resp_valid = 1'b1;
                  next_st.resp_err   = 1'b1;
               end
            end
         end
         ST_ACCESS: begin
            if (tmr_zero) begin
               next_st.oe_n    = 1'b1;
               next_st.we_n    = 1'b1;
               next_st.dq_oe_n = 1'b1;
               // Output-enable framing keeps the chip selected between steps
               next_st.ce_n = !(SEQ_USE_OE && nvsq_pkg::nvsq_is_seq(st.op)
                                && st.step != nvsq_pkg::SEQ_LAST_STEP);
               next_st.more  = 1'b0;
               next_st.state = ST_GAP;
               tmr_load      = 1'b1;
               tmr_value     = T_GAP;
               if (st.op == nvsq_pkg::OP_READ) begin
                  next_st.rdata = MEM_DQ_I;
               end
               if (nvsq_pkg::nvsq_is_seq(st.op)) begin
                  if (st.step != nvsq_pkg::SEQ_LAST_STEP) begin
                     next_st.step = st.step + 3'h1;
                     next_st.more = 1'b1;
                  end else if (st.op == nvsq_pkg::OP_RECALL) begin
                     next_st.state = ST_RECALL;
                     tmr_value     = T_RECALL;
                  end else if (st.op == nvsq_pkg::OP_SAVE) begin
                     next_st.state = ST_SAVE_START;
                     tmr_value     = T_SSTART;
                  end else if (AUTO_SAVE_PF) begin
                     next_st.op   = nvsq_pkg::OP_SAVE;
                     next_st.step = 3'h0;
                     next_st.more = 1'b1;
                  end
               end
            end
         end
         ST_GAP: begin
            if (tmr_zero) begin
               if (st.more) begin
                  next_st  = start_access(st);
                  tmr_load = 1'b1;
               end else begin
                  next_st.resp_valid = 1'b1;
                  next_st.state      = ST_IDLE;
               end
            end
         end
         ST_HW_PULSE: begin
            if (tmr_zero) begin
               next_st.busy_oe_n = 1'b1;
               next_st.state     = ST_SAVE_START;
               tmr_load          = 1'b1;
               tmr_value         = T_SSTART;
            end
         end
         ST_SAVE_START: begin
            if (tmr_zero) begin
               next_st.resp_due = 1'b1;
               next_st.state    = ST_WAIT_BUSY;
            end
         end
         ST_RECALL: begin
            if (tmr_zero) begin
               next_st.resp_due = 1'b1;
               next_st.state    = ST_WAIT_BUSY;
            end
         end
         ST_WAIT_BUSY: begin
            if (SAVE_BUSY_N_I) begin
               next_st.state = ST_HOLDOFF;
               tmr_load      = 1'b1;
               tmr_value     = T_POST;
            end
         end
         ST_HOLDOFF: begin
            if (tmr_zero) begin
               next_st.resp_valid = st.resp_due;
               next_st.resp_due   = 1'b0;
               next_st.state      = ST_IDLE;
            end
         end
         default: begin
            next_st.state = ST_IDLE;
         end
      endcase
   end

   // State register; reset waits for the power-up recall to end
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         st           <= '0;
         st.state     <= ST_WAIT_BUSY;
         st.ce_n      <= 1'b1;
         st.oe_n      <= 1'b1;
         st.we_n      <= 1'b1;
         st.byte_n    <= 2'h3;
         st.dq_oe_n   <= 1'b1;
         st.busy_oe_n <= 1'b1;
         st.busy      <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register, except the constant low busy drive
   assign REQ_READY_O               = st.ready;
   assign RESP_VALID_O              = st.resp_valid;
   assign RESP_ERR_O                = st.resp_err;
   assign RESP_RDATA_O              = st.rdata;
   assign BUSY_O                    = st.busy;
   assign MEM_ADDR_O                = st.addr;
   assign MEM_CE_N_O                = st.ce_n;
   assign MEM_OE_N_O                = st.oe_n;
   assign MEM_WE_N_O                = st.we_n;
   assign MEM_UPPER_BYTE_SELECT_N_O = st.byte_n[1];
   assign MEM_LOW_BYTE_SELECT_N_O   = st.byte_n[0];
   assign MEM_DQ_O                  = st.wdata;
   assign MEM_DQ_OE_N_O             = st.dq_oe_n;
   assign SAVE_BUSY_N_O             = 1'b0;       // Open drain: only ever pulls low
   assign SAVE_BUSY_N_OE_N_O        = st.busy_oe_n;
endmodule : nvsq_host

// ===== nvsq_host_monitor.sv
// Checker of the host controller request and memory pin behaviour
`timescale 1ns/1ps
module nvsq_host_monitor (
   input wire logic        CLK_I,
   input wire logic        RST_B_I,
   input wire logic        REQ_VALID_I,
   input wire logic [2:0]  REQ_OP_I,
   input wire logic        LOW_SUPPLY_I,
   input wire logic        REQ_READY_O,
   input wire logic        RESP_VALID_O,
   input wire logic        RESP_ERR_O,
   input wire logic [17:0] MEM_ADDR_O,
   input wire logic        MEM_CE_N_O,
   input wire logic        MEM_OE_N_O,
   input wire logic        MEM_WE_N_O,
   input wire logic        MEM_DQ_OE_N_O,
   input wire logic        SAVE_BUSY_N_I,
   input wire logic        SAVE_BUSY_N_OE_N_O
);
   logic [15:0] last_a;
   logic        take;
   assign take = REQ_VALID_I && REQ_READY_O && SAVE_BUSY_N_I;
   // Address of the latest chip-enable frame
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) last_a <= 16'h0000;
      else if (!MEM_CE_N_O) last_a <= MEM_ADDR_O[15:0];
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   refuse_low_a: assert property (take && LOW_SUPPLY_I && REQ_OP_I inside {3'h1, 3'h3, 3'h6} |=> RESP_VALID_O && RESP_ERR_O && MEM_CE_N_O && SAVE_BUSY_N_OE_N_O) else $error("refusal missing");
   read_we_high_a: assert property (!MEM_CE_N_O && !MEM_OE_N_O |-> MEM_WE_N_O && MEM_DQ_OE_N_O) else $error("read with write strobe");
   seq_second_a: assert property ($fell(MEM_CE_N_O) && MEM_ADDR_O[15:0] == 16'hB1C7 |-> last_a == 16'h4E38) else $error("step two out of order");
   seq_third_a: assert property ($fell(MEM_CE_N_O) && MEM_ADDR_O[15:0] == 16'h83E0 |-> last_a == 16'hB1C7) else $error("step three out of order");
   seq_fifth_a: assert property ($fell(MEM_CE_N_O) && MEM_ADDR_O[15:0] == 16'h703F |-> last_a == 16'h7C1F) else $error("step five out of order");
   seq_last_a: assert property ($fell(MEM_CE_N_O) && MEM_ADDR_O[15:0] inside {16'h4C63, 16'h8FC0, 16'h8B45, 16'h4B46} |-> last_a == 16'h703F) else $error("last step out of order");
   recall_quiet_a: assert property ($rose(MEM_CE_N_O) && last_a == 16'h4C63 |=> MEM_CE_N_O [*8]) else $error("access during recall");
   busy_holdoff_a: assert property ($rose(SAVE_BUSY_N_I) |-> !REQ_READY_O [*3]) else $error("ready too soon after busy");
   hw_pulse_a: assert property ($fell(SAVE_BUSY_N_OE_N_O) |-> !SAVE_BUSY_N_OE_N_O [*7]) else $error("save pulse short");
   resp_pulse_a: assert property (RESP_VALID_O |=> !RESP_VALID_O) else $error("response longer than one cycle");
   cover property ($rose(MEM_CE_N_O) && last_a == 16'h4C63);
   cover property (take && LOW_SUPPLY_I);
   cover property ($fell(SAVE_BUSY_N_OE_N_O));
endmodule : nvsq_host_monitor

bind nvsq_host nvsq_host_monitor nvsq_host_monitor_inst (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
   .REQ_VALID_I(REQ_VALID_I), .REQ_OP_I(REQ_OP_I), .LOW_SUPPLY_I(LOW_SUPPLY_I),
   .REQ_READY_O(REQ_READY_O), .RESP_VALID_O(RESP_VALID_O), .RESP_ERR_O(RESP_ERR_O),
   .MEM_ADDR_O(MEM_ADDR_O), .MEM_CE_N_O(MEM_CE_N_O), .MEM_OE_N_O(MEM_OE_N_O),
   .MEM_WE_N_O(MEM_WE_N_O), .MEM_DQ_OE_N_O(MEM_DQ_OE_N_O), .SAVE_BUSY_N_I(SAVE_BUSY_N_I),
   .SAVE_BUSY_N_OE_N_O(SAVE_BUSY_N_OE_N_O));

// ===== nvsq_mem_model.sv
// Behavioural model of the nonvolatile SRAM seen at its pins
`timescale 1ns/1ps
module nvsq_mem_model #(
   parameter int RECALL_CYC = 16,
   parameter int STORE_CYC  = 30
) (
   input  wire logic        clk_i,
   input  wire logic [17:0] addr_i,
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic [1:0]  byte_n_i,
   input  wire logic [15:0] dq_i,
   input  wire logic        low_supply_i,
   input  wire logic        busy_req_n_i,
   output logic [15:0]      dq_o,
   output logic             busy_n_o
);
   logic [15:0] sram [16];
   logic [15:0] nv [16];
   logic [15:0] key [5];
   logic        pf_en = 1'b1;
   logic        pf_nv = 1'b1;
   logic [2:0]  step = 3'h0;
   logic        rd_open = 1'b0;
   logic [15:0] rd_a = 16'h0000;
   logic [15:0] last_dq = 16'h0000;
   int          recall_left = 0;
   int          store_left = 0;
   // Factory contents and the fixed sequence prefix
   initial begin
      foreach (sram[i]) begin
         sram[i] = 16'h0000;
         nv[i] = 16'h0000;
      end
      key = '{16'h4E38, 16'hB1C7, 16'h83E0, 16'h7C1F, 16'h703F};
   end
   // Only address bits 14 to 2 take part in matching
   function automatic logic m(input logic [15:0] k);
      return k[14:2] == rd_a[14:2];
   endfunction : m
   assign busy_n_o = (store_left == 0);
   // Read data while selected for a read and not recalling, else a changing pattern
   always_comb begin
      if (!ce_n_i && !oe_n_i && we_n_i && recall_left == 0) dq_o = sram[addr_i[3:0]];
      else dq_o = ~last_dq;
   end
   // Accesses, sequence decoding, store and recall
   always @(posedge clk_i) begin
      last_dq <= dq_o;
      rd_open <= !ce_n_i && !oe_n_i && we_n_i;
      if (!ce_n_i && !oe_n_i) rd_a <= addr_i[15:0];
      if (recall_left > 0) begin
         if (recall_left == RECALL_CYC) foreach (sram[i]) sram[i] <= 16'h0000;
         if (recall_left == 1) foreach (sram[i]) sram[i] <= nv[i];
         recall_left <= recall_left - 1;
      end else if (store_left > 0) begin
         if (store_left == 1) begin
            foreach (nv[i]) nv[i] <= sram[i];
            pf_nv <= pf_en;
         end
         store_left <= store_left - 1;
      end else if (!busy_req_n_i) begin
         if (!low_supply_i) store_left <= STORE_CYC;
      end else if (!ce_n_i && !we_n_i) begin
         step <= 3'h0;
         if (!low_supply_i && !byte_n_i[0]) sram[addr_i[3:0]][7:0] <= dq_i[7:0];
         if (!low_supply_i && !byte_n_i[1]) sram[addr_i[3:0]][15:8] <= dq_i[15:8];
      end else if (rd_open && (ce_n_i || oe_n_i)) begin
         if (step < 3'h5) step <= m(key[step]) ? step + 3'h1 : {2'h0, m(key[0])};
         else begin
            step <= 3'h0;
            if (m(16'h4C63)) recall_left <= RECALL_CYC;
            if (m(16'h8FC0) && !low_supply_i) store_left <= STORE_CYC;
            if (m(16'h8B45)) pf_en <= 1'b0;
            if (m(16'h4B46)) pf_en <= 1'b1;
         end
      end
   end
endmodule : nvsq_mem_model

// ===== testbench.sv
// Self-checking testbench of the host controller against the memory model
`timescale 1ns/1ps
module testbench;
   logic        CLK_I = 1'b0;
   logic        RST_B_I = 1'b0;
   logic        REQ_VALID_I = 1'b0;
   logic [2:0]  REQ_OP_I = 3'h0;
   logic [17:0] REQ_ADDR_I = 18'h00000;
   logic [15:0] REQ_WDATA_I = 16'h0000;
   logic [1:0]  REQ_BYTE_N_I = 2'h0;
   logic        LOW_SUPPLY_I = 1'b0;
   logic        ready, rvalid, rerr, busy, ce_n, oe_n, we_n, ub_n, lb_n, dq_oe_n, bz, bz_oe_n;
   logic        busy_n, model_busy_n, err;
   logic [15:0] rdata, dq_h, dq_m, rd;
   logic [17:0] addr;
   logic        ce2, oe2, we2, ub2, lb2, dq_oe2, bz2, bz_oe2, busy_n2, mbusy2;
   logic [15:0] rdata2, dq_h2, dq_m2;
   logic [17:0] addr2;
   int          oe_gaps = 0;
   int          n_mismatch = 0;
   int          total_checks = 0;
   always #4 CLK_I = ~CLK_I;
   // Busy pin has a pull-up; either party may pull it low
   assign busy_n = model_busy_n & (bz_oe_n | bz);
   nvsq_host #(.RECALL_WAIT_CYC(20)) nvsq_host_inst (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
      .REQ_VALID_I(REQ_VALID_I), .REQ_OP_I(REQ_OP_I), .REQ_ADDR_I(REQ_ADDR_I),
      .REQ_WDATA_I(REQ_WDATA_I), .REQ_BYTE_N_I(REQ_BYTE_N_I), .LOW_SUPPLY_I(LOW_SUPPLY_I),
      .REQ_READY_O(ready), .RESP_VALID_O(rvalid), .RESP_ERR_O(rerr), .RESP_RDATA_O(rdata),
      .BUSY_O(busy), .MEM_ADDR_O(addr), .MEM_CE_N_O(ce_n), .MEM_OE_N_O(oe_n),
      .MEM_WE_N_O(we_n), .MEM_UPPER_BYTE_SELECT_N_O(ub_n), .MEM_LOW_BYTE_SELECT_N_O(lb_n),
      .MEM_DQ_I(dq_m), .MEM_DQ_O(dq_h), .MEM_DQ_OE_N_O(dq_oe_n), .SAVE_BUSY_N_I(busy_n),
      .SAVE_BUSY_N_O(bz), .SAVE_BUSY_N_OE_N_O(bz_oe_n));
   nvsq_mem_model nvsq_mem_model_inst (.clk_i(CLK_I), .addr_i(addr), .ce_n_i(ce_n),
      .oe_n_i(oe_n), .we_n_i(we_n), .byte_n_i({ub_n, lb_n}), .dq_i(dq_h),
      .low_supply_i(LOW_SUPPLY_I), .busy_req_n_i(bz_oe_n | bz), .dq_o(dq_m),
      .busy_n_o(model_busy_n));
   // Second host frames sequence steps by output-enable and runs in lock step with the first
   assign busy_n2 = mbusy2 & (bz_oe2 | bz2);
   nvsq_host #(.RECALL_WAIT_CYC(20), .SEQ_USE_OE(1'b1)) nvsq_host_oe_inst (.CLK_I(CLK_I),
      .RST_B_I(RST_B_I), .REQ_VALID_I(REQ_VALID_I), .REQ_OP_I(REQ_OP_I),
      .REQ_ADDR_I(REQ_ADDR_I), .REQ_WDATA_I(REQ_WDATA_I), .REQ_BYTE_N_I(REQ_BYTE_N_I),
      .LOW_SUPPLY_I(LOW_SUPPLY_I), .REQ_READY_O(), .RESP_VALID_O(), .RESP_ERR_O(),
      .RESP_RDATA_O(rdata2), .BUSY_O(), .MEM_ADDR_O(addr2), .MEM_CE_N_O(ce2),
      .MEM_OE_N_O(oe2), .MEM_WE_N_O(we2), .MEM_UPPER_BYTE_SELECT_N_O(ub2),
      .MEM_LOW_BYTE_SELECT_N_O(lb2), .MEM_DQ_I(dq_m2), .MEM_DQ_O(dq_h2),
      .MEM_DQ_OE_N_O(dq_oe2), .SAVE_BUSY_N_I(busy_n2), .SAVE_BUSY_N_O(bz2),
      .SAVE_BUSY_N_OE_N_O(bz_oe2));
   nvsq_mem_model nvsq_mem_model_oe_inst (.clk_i(CLK_I), .addr_i(addr2), .ce_n_i(ce2),
      .oe_n_i(oe2), .we_n_i(we2), .byte_n_i({ub2, lb2}), .dq_i(dq_h2),
      .low_supply_i(LOW_SUPPLY_I), .busy_req_n_i(bz_oe2 | bz2), .dq_o(dq_m2),
      .busy_n_o(mbusy2));
   // Counts cycles of gaps that keep the chip selected, which only output-enable framing makes
   always @(posedge CLK_I) begin
      if (!ce2 && oe2 && we2) oe_gaps <= oe_gaps + 1;
   end
   // Compare and count
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // One request: wait for ready, present it one edge, wait for the response
   task automatic request(input logic [2:0] op, input logic [17:0] a, input logic [15:0] wd);
      int   n;
      logic exp_busy;
      n = 0;
      while (ready !== 1'b1 && n < 1000) begin
         @(posedge CLK_I);
         #1;
         n++;
      end
      @(posedge CLK_I);
      REQ_VALID_I <= 1'b1;
      REQ_OP_I <= op;
      REQ_ADDR_I <= a;
      REQ_WDATA_I <= wd;
      @(posedge CLK_I);
      REQ_VALID_I <= 1'b0;
      n = 0;
      #1;
      exp_busy = !(op == 3'h7 || (LOW_SUPPLY_I && op inside {3'h1, 3'h3, 3'h6}));
      check("busy at take", {15'h0, busy}, {15'h0, exp_busy});
      while (rvalid !== 1'b1 && n < 2000) begin
         @(posedge CLK_I);
         #1;
         n++;
      end
      if (n == 2000) n_mismatch++;
      err = rerr;
      rd = rdata;
      @(posedge CLK_I);
      #1;
      check("ready again", {15'h0, ready}, 16'h0001);
      check("busy idle", {15'h0, busy}, 16'h0000);
   endtask : request
   task automatic t_factory;
      request(3'h0, 18'h00009, 16'h0000);
      check("factory word", rd, 16'h0000);
      check("factory pf", {15'h0, nvsq_mem_model_inst.pf_en}, 16'h0001);
   endtask : t_factory
   task automatic t_save;
      request(3'h1, 18'h00005, 16'h1357);
      request(3'h3, 18'h00000, 16'h0000);
      check("save err", {15'h0, err}, 16'h0000);
      check("saved word", nvsq_mem_model_inst.nv[5], 16'h1357);
      check("oe saved word", nvsq_mem_model_oe_inst.nv[5], 16'h1357);
      check("oe framing", {15'h0, oe_gaps != 0}, 16'h0001);
   endtask : t_save
   task automatic t_recall;
      request(3'h1, 18'h00005, 16'h2468);
      request(3'h2, 18'h00000, 16'h0000);
      request(3'h0, 18'h00005, 16'h0000);
      check("recalled word", rd, 16'h1357);
      check("oe recalled word", rdata2, 16'h1357);
      check("nv kept", nvsq_mem_model_inst.nv[5], 16'h1357);
   endtask : t_recall
   task automatic t_pf;
      request(3'h4, 18'h00000, 16'h0000);
      check("pf off", {15'h0, nvsq_mem_model_inst.pf_en}, 16'h0000);
      check("oe pf off", {15'h0, nvsq_mem_model_oe_inst.pf_en}, 16'h0000);
      check("pf off kept", {15'h0, nvsq_mem_model_inst.pf_nv}, 16'h0000);
      request(3'h5, 18'h00000, 16'h0000);
      check("pf on", {15'h0, nvsq_mem_model_inst.pf_en}, 16'h0001);
      check("pf on kept", {15'h0, nvsq_mem_model_inst.pf_nv}, 16'h0001);
   endtask : t_pf
   task automatic t_hw;
      request(3'h1, 18'h00005, 16'hBEEF);
      request(3'h6, 18'h00000, 16'h0000);
      check("hw saved", nvsq_mem_model_inst.nv[5], 16'hBEEF);
   endtask : t_hw
   task automatic t_low;
      @(posedge CLK_I);
      LOW_SUPPLY_I <= 1'b1;
      request(3'h1, 18'h00005, 16'h0F0F);
      check("write refused", {15'h0, err}, 16'h0001);
      request(3'h3, 18'h00000, 16'h0000);
      check("save refused", {15'h0, err}, 16'h0001);
      request(3'h6, 18'h00000, 16'h0000);
      check("hw refused", {15'h0, err}, 16'h0001);
      request(3'h7, 18'h00000, 16'h0000);
      check("op refused", {15'h0, err}, 16'h0001);
      @(posedge CLK_I);
      LOW_SUPPLY_I <= 1'b0;
      request(3'h0, 18'h00005, 16'h0000);
      check("word kept", rd, 16'hBEEF);
   endtask : t_low
   task automatic test_done;
      $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (10) @(posedge CLK_I);
      RST_B_I <= 1'b1;
      t_factory;
      t_save;
      t_recall;
      t_pf;
      t_hw;
      t_low;
      test_done;
   end
   initial begin
      repeat (30000) @(posedge CLK_I);
      n_mismatch++;
      test_done;
   end
endmodule : testbench
